// ---- core/phybmc_ctrl.sv ----
/*
 * basic mode control register of the phy, with soft reset sequencing,
 * power down, isolate, restart negotiation, forced mode and collision test.
 * assumes the management engine gives single-cycle read and write strobes
 * on this clock, and the negotiation engine acknowledges a restart.
 */
// Function
// - a set power-down bit shuts down the phy except for this register block.
// - power down is the or of the bit and the active-low pin, and the pin low sets the bit.
// - the isolate bit cuts the port from the mii while management keeps working.
// - writing one to the restart bit restarts negotiation, ignored when negotiation is disabled.
// - the restart bit reads one until negotiation has started, then clears itself.
// - writing zero to a set restart bit does not disturb a running negotiation.
// - with negotiation off the duplex bit picks full or half duplex, reset from a strap.
// - in collision test col rises within 512 bit times of transmit enable.
// - in collision test col falls within 4 bit times of transmit enable dropping.
// - bits six to zero ignore writes and read as zero.
// - with negotiation on, the speed and duplex bits are ignored.
// - with negotiation off the speed bit picks 100 or 10 mb/s.
// - the soft reset bit reloads the straps, reads one while busy and then clears.
module phybmc_ctrl
  import phybmc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic power_down_irq_pin_n_i,
  input wire logic strap_an_en_i,
  input wire logic strap_speed_i,
  input wire logic strap_duplex_i,
  input wire logic an_started_i,
  input wire logic an_speed_100_i,
  input wire logic an_full_duplex_i,
  input wire logic tx_en_i,
  output logic col_o,
  output logic power_down_o,
  output logic phy_enable_o,
  output logic isolate_o,
  output logic loopback_o,
  output logic an_enable_o,
  output logic an_restart_o,
  output logic mode_speed_100_o,
  output logic mode_full_duplex_o,
  output logic sw_reset_busy_o
);

  logic pd_meta;
  logic pd_sync_n;
  logic pd_pin_low;
  logic [2:0] strap_meta;
  logic [2:0] strap_sync;
  logic sw_rst;
  logic loopback;
  logic speed;
  logic an_en;
  logic pd;
  logic isolate;
  logic restart;
  logic duplex;
  logic coltest;
  logic strap_load;
  logic rst_done;
  logic wr;
  logic [15:0] next_rdata;
  logic [RST_CNT_W-1:0] rst_cnt;
  phybmc_rst_st_t rst_st;
  phybmc_col_if col_if ();

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk_sys_i) begin
    pd_meta <= power_down_irq_pin_n_i;
    pd_sync_n <= pd_meta;
    strap_meta <= {strap_an_en_i, strap_speed_i, strap_duplex_i};
    strap_sync <= strap_meta;
  end

  // pin is active low; invert only after both stages
  assign pd_pin_low = !pd_sync_n;

  // writes land only on this register and not during soft reset
  assign wr = reg_wr_i && (reg_addr_i == BMC_ADDR) && !sw_rst;

  // soft reset sequencer
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rst_st <= PHYBMC_IDLE;
      rst_cnt <= RST_CNT_ZERO;
    end else begin
      unique case (rst_st)
        PHYBMC_IDLE: begin
          if (wr && reg_wdata_i[BIT_SW_RST]) begin
            rst_st <= PHYBMC_BUSY;
            rst_cnt <= RST_CNT_LOAD;
          end
        end
        PHYBMC_BUSY: begin
          rst_cnt <= rst_cnt - RST_CNT_LAST;
          if (rst_cnt == RST_CNT_LAST) begin
            rst_st <= PHYBMC_RELOAD;
          end
        end
        PHYBMC_RELOAD: begin
          rst_st <= PHYBMC_IDLE;
        end
        default: begin
          rst_st <= PHYBMC_IDLE; // unused code falls back to idle
        end
      endcase
    end
  end

  assign rst_done = (rst_st == PHYBMC_RELOAD);

  // soft reset bit reads one until the reload is finished
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sw_rst <= BMC_RESET[BIT_SW_RST];
    end else if (wr && reg_wdata_i[BIT_SW_RST]) begin
      sw_rst <= 1'b1;
    end else if (rst_done) begin
      sw_rst <= 1'b0;
    end
  end

  // straps are caught after reset release and after soft reset
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      strap_load <= 1'b1;
    end else begin
      strap_load <= rst_done;
    end
  end

  // strap-backed fields: negotiation enable, speed, duplex
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      an_en <= BMC_RESET[BIT_AN_EN];
      speed <= BMC_RESET[BIT_SPEED];
      duplex <= BMC_RESET[BIT_DUPLEX];
    end else if (strap_load) begin
      {an_en, speed, duplex} <= strap_sync;
    end else if (wr) begin
      an_en <= reg_wdata_i[BIT_AN_EN];
      speed <= reg_wdata_i[BIT_SPEED];
      duplex <= reg_wdata_i[BIT_DUPLEX];
    end
  end

  // plain read-write fields
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || rst_done) begin
      loopback <= BMC_RESET[BIT_LOOPBACK];
      isolate <= BMC_RESET[BIT_ISOLATE];
      coltest <= BMC_RESET[BIT_COLTEST];
    end else if (wr) begin
      loopback <= reg_wdata_i[BIT_LOOPBACK];
      isolate <= reg_wdata_i[BIT_ISOLATE];
      coltest <= reg_wdata_i[BIT_COLTEST];
    end
  end

  // power-down bit; the pin held low sets it and wins over a clear
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pd <= BMC_RESET[BIT_PWR_DOWN];
    end else if (pd_pin_low) begin
      pd <= 1'b1;
    end else if (rst_done) begin
      pd <= BMC_RESET[BIT_PWR_DOWN];
    end else if (wr) begin
      pd <= reg_wdata_i[BIT_PWR_DOWN];
    end
  end

  // restart bit: set by a one with negotiation on, cleared by the engine or a soft reset
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || rst_done) begin
      restart <= BMC_RESET[BIT_RESTART];
    end else if (wr && reg_wdata_i[BIT_RESTART] && reg_wdata_i[BIT_AN_EN]) begin
      restart <= 1'b1;
    end else if (an_started_i) begin
      restart <= 1'b0;
    end
  end

  // restart request pulse to the negotiation engine
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      an_restart_o <= 1'b0;
    end else begin
      an_restart_o <= wr && reg_wdata_i[BIT_RESTART] && reg_wdata_i[BIT_AN_EN];
    end
  end

  // operating mode and power outputs
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      power_down_o <= 1'b0;
      phy_enable_o <= 1'b0;
      isolate_o <= 1'b0;
      loopback_o <= 1'b0;
      an_enable_o <= 1'b0;
      mode_speed_100_o <= 1'b0;
      mode_full_duplex_o <= 1'b0;
      sw_reset_busy_o <= 1'b0;
    end else begin
      power_down_o <= pd | pd_pin_low;
      phy_enable_o <= !(pd | pd_pin_low);
      isolate_o <= isolate;
      loopback_o <= loopback;
      an_enable_o <= an_en;
      mode_speed_100_o <= an_en ? an_speed_100_i : speed;
      mode_full_duplex_o <= an_en ? an_full_duplex_i : duplex;
      sw_reset_busy_o <= sw_rst;
    end
  end

  // read image; reserved bits are constant zero
  always_comb begin
    next_rdata = BMC_RESET;
    if (reg_addr_i == BMC_ADDR) begin
      next_rdata = {sw_rst, loopback, speed, an_en, pd, isolate, restart, duplex, coltest,
        RSVD_READ};
    end
  end

  // read port, answer one edge after the strobe; register block never gated
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= BMC_RESET;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // collision test logic
  assign col_if.coltest_en = coltest;
  assign col_o = col_if.col;

  phybmc_coltest u_coltest (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .tx_en_i(tx_en_i),
    .col_if(col_if)
  );

  localparam int SWR_MAX = 210;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence seq_sw_reset_start;
    reg_wr_i && reg_addr_i == BMC_ADDR && !sw_rst && reg_wdata_i[BIT_SW_RST];
  endsequence

  sequence seq_sw_reset_done;
    !sw_rst && strap_load;
  endsequence

  a_sw_reset_busy:
    assert property (seq_sw_reset_start |=> sw_rst [*8])
    else $error("soft reset bit dropped too early");

  a_sw_reset_end:
    assert property (seq_sw_reset_start |-> ##[1:SWR_MAX] seq_sw_reset_done)
    else $error("soft reset did not finish and reload straps");

  a_restart_pulse:
    assert property (wr && reg_wdata_i[BIT_RESTART] && reg_wdata_i[BIT_AN_EN] |=> an_restart_o && restart)
    else $error("restart write did not start negotiation");

  a_restart_ignored:
    assert property (wr && !reg_wdata_i[BIT_AN_EN] && !restart |=> !restart && !an_restart_o)
    else $error("restart taken with negotiation disabled");

  a_restart_hold:
    assert property (restart && !an_started_i && !rst_done |=> restart)
    else $error("restart bit cleared before negotiation started");

  a_restart_selfclr:
    assert property (restart && an_started_i && !wr |=> !restart)
    else $error("restart bit did not self clear");

  a_restart_no_abort:
    assert property (restart && wr && !reg_wdata_i[BIT_RESTART] && !an_started_i |=> restart)
    else $error("writing zero disturbed restart");

  a_pd_pin_sets:
    assert property (pd_pin_low |=> pd ##1 power_down_o && !phy_enable_o)
    else $error("power-down pin did not set the bit");

  a_pd_effective:
    assert property (!$past(sys_rst_i) |-> power_down_o == !phy_enable_o)
    else $error("phy enabled while powered down");

  a_isolate_out:
    assert property (wr |=> ##1 isolate_o == $past(reg_wdata_i[BIT_ISOLATE], 2))
    else $error("isolate output does not follow written bit");

  a_reserved_zero:
    assert property (reg_rvalid_o |-> reg_rdata_o[6:0] == RSVD_READ)
    else $error("reserved bits read nonzero");

  a_forced_mode:
    assert property (!an_en ##1 !$past(sys_rst_i) |-> mode_speed_100_o == $past(speed)
      && mode_full_duplex_o == $past(duplex))
    else $error("forced speed or duplex not applied");

  a_col_enable:
    assert property (!coltest |=> !col_o)
    else $error("col asserted outside collision test");

endmodule // phybmc_ctrl

// ---- core/phybmc_pkg.sv ----
/*
 * constants of the basic mode control register block.
 * assumes a 200 MHz management clock.
 */
package phybmc_pkg;

  // register index and width
  localparam logic [4:0] BMC_ADDR = 5'h00;
  localparam int BMC_W = 16;
  localparam logic [15:0] BMC_RESET = 16'h0000;

  // field positions
  localparam int BIT_SW_RST = 15;
  localparam int BIT_LOOPBACK = 14;
  localparam int BIT_SPEED = 13;
  localparam int BIT_AN_EN = 12;
  localparam int BIT_PWR_DOWN = 11;
  localparam int BIT_ISOLATE = 10;
  localparam int BIT_RESTART = 9;
  localparam int BIT_DUPLEX = 8;
  localparam int BIT_COLTEST = 7;
  localparam logic [6:0] RSVD_READ = 7'h00;

  // clock and timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BIT_TIME_PS = 10000;
  localparam int SW_RST_TIME_NS = 1000;
  localparam int SW_RST_CYC = (SW_RST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int COL_RISE_BITS = 512;
  localparam int COL_FALL_BITS = 4;
  localparam int COL_RISE_MAX_CYC = COL_RISE_BITS * BIT_TIME_PS / CLK_PERIOD_PS;
  localparam int COL_FALL_MAX_CYC = COL_FALL_BITS * BIT_TIME_PS / CLK_PERIOD_PS;
  localparam int RST_CNT_W = 8;
  localparam logic [7:0] RST_CNT_LOAD = 8'(SW_RST_CYC);
  localparam logic [7:0] RST_CNT_LAST = 8'h01;
  localparam logic [7:0] RST_CNT_ZERO = 8'h00;

  // soft reset sequencer states
  typedef enum logic [1:0] {
    PHYBMC_IDLE,
    PHYBMC_BUSY,
    PHYBMC_RELOAD
  } phybmc_rst_st_t;

endpackage

// ---- core/phybmc_col_if.sv ----
/*
 * link between the control register and the collision test logic.
 * assumes both ends run on the management clock.
 */
interface phybmc_col_if;
  logic coltest_en;
  logic col;

  modport ctrl (output coltest_en, input col);
  modport coltest (input coltest_en, output col);
endinterface

// ---- core/phybmc_coltest.sv ----
/*
 * collision test: col follows the transmit enable pin while enabled.
 * assumes tx_en comes from another clock domain and is synchronised here.
 */
module phybmc_coltest
  import phybmc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic tx_en_i,
  phybmc_col_if.coltest col_if
);

  logic tx_en_meta;
  logic tx_en_sync;

  // two-stage synchroniser for the transmit enable pin
  always_ff @(posedge clk_sys_i) begin
    tx_en_meta <= tx_en_i;
    tx_en_sync <= tx_en_meta;
  end

  // col is the gated transmit enable, three edges behind the pin
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      col_if.col <= 1'b0;
    end else begin
      col_if.col <= col_if.coltest_en & tx_en_sync;
    end
  end

  localparam int RISE_MAX = 4;
  localparam int FALL_MAX = 4;

  a_col_rise_bound:
    assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      ($rose(tx_en_sync) && col_if.coltest_en) ##1 col_if.coltest_en |-> ##[0:RISE_MAX] col_if.col)
    else $error("col did not follow transmit enable in time");

  a_col_fall_bound:
    assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      $fell(tx_en_sync) |-> ##[1:FALL_MAX] !col_if.col)
    else $error("col held after transmit enable dropped");

endmodule // phybmc_coltest

// ---- tb/phybmc_an_model.sv ----
/*
 * negotiation engine stand-in: answers a restart request with a start pulse.
 * assumes the control block's clock; the bench sets the answer delay.
 */
module phybmc_an_model (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic an_restart_i,
  input wire logic [7:0] delay_i,
  output logic an_started_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  logic busy;
  // count out the delay, then pulse start once
  always_ff @(posedge clk_sys_i) begin
    an_started_o <= 1'b0;
    if (sys_rst_i) begin
      busy <= 1'b0;
      cnt <= 8'h00;
    end else if (an_restart_i) begin
      busy <= 1'b1;
      cnt <= delay_i;
    end else if (busy) begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h00) begin
        busy <= 1'b0;
        an_started_o <= 1'b1;
      end
    end
  end
endmodule // phybmc_an_model

// ---- tb/phybmc_ctrl_tb_top.sv ----
/*
 * self-checking bench of the basic mode control register block.
 * assumes single-cycle strobes and a negotiation engine stand-in.
 */
module phybmc_ctrl_tb_top;
  import phybmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [15:0] w; logic [15:0] r; logic [5:0] o;} phybmc_row_t;
  logic clk_sys_i, sys_rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, power_down_irq_pin_n_i;
  logic strap_an_en_i, strap_speed_i, strap_duplex_i, an_started_i, an_speed_100_i;
  logic an_full_duplex_i, tx_en_i, col_o, power_down_o, phy_enable_o, isolate_o;
  logic loopback_o, an_enable_o, an_restart_o, mode_speed_100_o, mode_full_duplex_o;
  logic sw_reset_busy_o;
  logic [4:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, rdat;
  logic [7:0] an_delay;
  logic [5:0] outs;
  int fail_count = 0;
  int tests_run = 0;
  int restarts = 0;
  phybmc_row_t rows [8] = '{'{16'h2100, 16'h2100, 6'h03}, '{16'h0000, 16'h0000, 6'h00},
    '{16'h007f, 16'h0000, 6'h00}, '{16'h0400, 16'h0400, 6'h10}, '{16'h0800, 16'h0800, 6'h20},
    '{16'h4000, 16'h4000, 6'h08}, '{16'h3100, 16'h3100, 6'h05}, '{16'h0080, 16'h0080, 6'h00}};
  assign outs = {power_down_o, isolate_o, loopback_o, an_enable_o, mode_speed_100_o, mode_full_duplex_o};

  phybmc_ctrl dut (.*);
  phybmc_an_model u_an (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .an_restart_i(an_restart_o),
    .delay_i(an_delay), .an_started_o(an_started_i));

  // clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // count restart pulses
  always @(posedge clk_sys_i) begin
    if (an_restart_o === 1'b1) restarts++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= 5'h00;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    rdat = reg_rdata_o;
    chk({15'h0000, reg_rvalid_o}, 16'h0001);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    rd(a);
    chk(rdat, exp);
  endtask
  task automatic wait_col(input logic v, input int n);
    int i;
    i = 0;
    while (col_o !== v && i < n) begin
      @(posedge clk_sys_i);
      #1;
      i++;
    end
    chk({15'h0000, col_o}, {15'h0000, v});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // watchdog
  initial begin
    #100000;
    fail_count++;
    $display("BAD t=%0t watchdog expired", $time);
    results();
  end

  // main sequence
  initial begin
    {sys_rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, tx_en_i} = '0;
    sys_rst_i = 1'b1;
    power_down_irq_pin_n_i = 1'b1;
    {strap_an_en_i, strap_speed_i, strap_duplex_i} = 3'h3;
    {an_speed_100_i, an_full_duplex_i} = 2'h1;
    an_delay = 8'h28;
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rchk(5'h00, 16'h2100);
    rchk(5'h01, 16'h0000);
    $display("reset done");
    for (int i = 0; i < 8; i++) begin
      wr(rows[i].w);
      rchk(5'h00, rows[i].r);
      chk({10'h000, outs}, {10'h000, rows[i].o});
      chk({15'h0000, phy_enable_o}, {15'h0000, ~rows[i].o[5]});
    end
    $display("table done");
    // restart held until the slow engine starts, zero write ignored
    wr(16'h1200);
    #1;
    chk({15'h0000, an_restart_o}, 16'h0001);
    rchk(5'h00, 16'h1200);
    wr(16'h1000);
    rchk(5'h00, 16'h1200);
    for (int i = 0; i < 100 && an_started_i !== 1'b1; i++) @(posedge clk_sys_i);
    repeat (2) @(posedge clk_sys_i);
    rchk(5'h00, 16'h1000);
    wr(16'h0200);
    rchk(5'h00, 16'h0000);
    chk(16'(restarts), 16'h0001);
    $display("restart done");
    // collision test on and off
    wr(16'h0080);
    @(posedge clk_sys_i);
    tx_en_i <= 1'b1;
    wait_col(1'b1, COL_RISE_MAX_CYC);
    @(posedge clk_sys_i);
    tx_en_i <= 1'b0;
    wait_col(1'b0, COL_FALL_MAX_CYC);
    wr(16'h0000);
    @(posedge clk_sys_i);
    tx_en_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    #1;
    chk({15'h0000, col_o}, 16'h0000);
    $display("collision done");
    // power-down pin sets the bit, registers stay reachable
    @(posedge clk_sys_i);
    tx_en_i <= 1'b0;
    power_down_irq_pin_n_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    #1;
    chk({14'h0000, power_down_o, phy_enable_o}, 16'h0002);
    wr(16'h0000);
    rchk(5'h00, 16'h0800);
    @(posedge clk_sys_i);
    power_down_irq_pin_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    wr(16'h0000);
    rchk(5'h00, 16'h0000);
    chk({15'h0000, power_down_o}, 16'h0000);
    $display("power down done");
    // soft reset reloads changed straps, ignores writes while busy
    {strap_an_en_i, strap_speed_i, strap_duplex_i} <= 3'h4;
    wr(16'h8000);
    rchk(5'h00, 16'h8000);
    chk({15'h0000, sw_reset_busy_o}, 16'h0001);
    wr(16'h0400);
    for (int i = 0; i < 150 && rdat[15] !== 1'b0; i++) rd(5'h00);
    rchk(5'h00, 16'h1000);
    $display("soft reset done");
    // mid-run reset clears the fields and catches the straps again
    wr(16'h0480);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk({13'h0000, isolate_o, col_o, sw_reset_busy_o}, 16'h0000);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rchk(5'h00, 16'h1000);
    $display("mid reset done");
    results();
  end
endmodule // phybmc_ctrl_tb_top
